// ### core/spc_params.svh
// constants of the serial packet check unit
// assumes inclusion by spc_crc_link, the only design file of the unit that includes it
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

`define SPC_POLY       16'h4599
`define SPC_SEED       16'h0010
`define SPC_TOP_BIT    16'h4000
`define SPC_TBL_SIZE   256
`define SPC_BYTE_BITS  8
`define SPC_FIFO_DEPTH 8
`define SPC_FIFO_WIDTH 9
`define SPC_BIT_LAST   3'h7
`define SPC_CNT_CODE   2'h2
`define SPC_CNT_FULL   2'h3

`endif

// ### core/spc_pkg.sv
// types of the serial packet check unit
// assumes spc_params.svh alongside
package spc_pkg;

    // payload byte stream and frame verdict toward the user
    typedef struct packed {
        logic [7:0] data;
        logic       valid;
        logic       done;
        logic       ok;
    } spc_wr_out_t;

    // outgoing read payload bytes from the user
    typedef struct packed {
        logic       clear;
        logic       valid;
        logic [7:0] data;
    } spc_rd_in_t;

    // fifo entry: a byte, or a frame end with overflow in bit 0
    typedef struct packed {
        logic       is_end;
        logic [7:0] data;
    } spc_entry_t;

    // link side shifter, cleared between frames
    typedef struct packed {
        logic [7:0] sh;
        logic [2:0] cnt;
    } spc_lshift_t;

    // link side byte hand-off
    typedef struct packed {
        logic [7:0] byte_hold;
        logic       tog;
    } spc_lhold_t;

    // core side state
    typedef struct packed {
        logic [2:0]  tog_s;
        logic        tog_acc;
        logic [2:0]  cs_s;
        logic        cs_acc;
        logic        pend_end;
        logic        ovf;
        logic [7:0]  cap;
        logic        cap_v;
        logic [15:0] rem;
        logic [1:0]  cnt;
        logic [7:0]  h0;
        logic [7:0]  h1;
        spc_wr_out_t wr;
        logic [15:0] rd_rem;
        logic [15:0] rd_code;
    } spc_core_t;

endpackage : spc_pkg

// ### core/spc_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module spc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } spc_fifo_st_t;

    spc_fifo_st_t f_r;
    spc_fifo_st_t f_nxt;
    logic         full;
    logic         empty;

    assign full      = (f_r.wp[AW] != f_r.rp[AW]) &&
                       (f_r.wp[AW-1:0] == f_r.rp[AW-1:0]);
    assign empty     = (f_r.wp == f_r.rp);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = f_r.mem[f_r.rp[AW-1:0]];

    always_comb begin
        f_nxt = f_r;
        if (in_valid && !full) begin
            f_nxt.mem[f_r.wp[AW-1:0]] = in_data;
            f_nxt.wp = f_r.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            f_nxt.rp = f_r.rp + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            f_r <= '0;
        end else begin
            f_r <= f_nxt;
        end
    end

endmodule : spc_fifo

// ### core/spc_crc_link.sv
// packet check code unit on the serial command link
// assumes link_clk runs while reset is high and during frames only
//
// Functional notes
// [RULE1] every payload carries a sender-computed check code
// [RULE2] 15-bit check, polynomial 0x4599 on top bit
// [RULE3] remainder preset to 16 per payload
// [RULE4] 256 table entries: index<<7, eight conditional shifts
// [RULE5] index from remainder>>7 xor byte; shift eight
// [RULE6] sent code is remainder times two
// [RULE7] any byte count, folded in order; write frames with no payload byte are refused
// [RULE8] master clock 1MHz only up to 10m
// [RULE9] mismatching received code marks write invalid
`timescale 1ns/1ps
`include "spc_params.svh"
module spc_crc_link (
    input  wire logic          core_clk,
    input  wire logic          reset,
    input  wire logic          link_clk,
    input  wire logic          link_cs_n,
    input  wire logic          link_mosi,
    input  wire logic          wr_ready,
    output spc_pkg::spc_wr_out_t wr_out,
    input  spc_pkg::spc_rd_in_t  rd_in,
    output logic [15:0]        rd_code
);
    import spc_pkg::*;

    localparam logic [15:0] SEED_L    = `SPC_SEED;
    localparam logic [15:0] POLY_L    = `SPC_POLY;
    localparam logic [15:0] SEED_CODE = {SEED_L[14:0], 1'b0};

    // check table, built from the polynomial
    logic [15:0] check_lookup_table [`SPC_TBL_SIZE];

    function automatic logic [15:0] make_entry(input logic [7:0] idx);
        logic [15:0] r;
        r = {1'b0, idx, 7'h00};
        for (int b = 0; b < `SPC_BYTE_BITS; b++) begin
            if ((r & `SPC_TOP_BIT) != 16'h0000) begin
                r = (r << 1) ^ `SPC_POLY; // [RULE2] [RULE4]
            end else begin
                r = r << 1;
            end
        end
        return r;
    endfunction : make_entry

    always_comb begin
        for (int i = 0; i < `SPC_TBL_SIZE; i++) begin
            check_lookup_table[i] = make_entry(8'(i)); // [RULE4]
        end
    end

    function automatic logic [15:0] crc_step(input logic [15:0] rem,
                                             input logic [7:0]  b);
        logic [7:0] idx;
        idx = rem[14:7] ^ b;
        return (rem << `SPC_BYTE_BITS) ^ check_lookup_table[idx]; // [RULE5]
    endfunction : crc_step

    // bit serial reference, used by the checks only
    function automatic logic [14:0] bit_step(input logic [15:0] rem,
                                             input logic [7:0]  b);
        logic [14:0] r;
        r = rem[14:0] ^ {b, 7'h00};
        for (int k = 0; k < `SPC_BYTE_BITS; k++) begin
            if (r[14]) begin
                r = (r << 1) ^ POLY_L[14:0];
            end else begin
                r = r << 1;
            end
        end
        return r;
    endfunction : bit_step

    // link domain: shifter cleared by chip select
    spc_lshift_t s_r;
    spc_lshift_t s_nxt;
    spc_lhold_t  h_r;
    spc_lhold_t  h_nxt;
    logic [2:0]  lrs_r;
    logic        lrst_r;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.sh  = {s_r.sh[6:0], link_mosi};
        s_nxt.cnt = s_r.cnt + 1'b1;
    end

    always_ff @(posedge link_clk or posedge link_cs_n) begin
        if (link_cs_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        h_nxt = h_r;
        if (!link_cs_n && s_r.cnt == `SPC_BIT_LAST) begin
            h_nxt.byte_hold = {s_r.sh[6:0], link_mosi}; // [RULE7]
            h_nxt.tog       = ~h_r.tog;
        end
    end

    // core reset carried into the link domain
    always_ff @(posedge link_clk) begin
        lrs_r <= {lrs_r[1:0], reset};
        if (lrs_r[1] == lrs_r[2]) begin
            lrst_r <= lrs_r[1];
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            h_r <= '0;
        end else begin
            h_r <= h_nxt;
        end
    end

    // core domain
    spc_core_t   c_r;
    spc_core_t   c_nxt;
    logic        push_v;
    spc_entry_t  push_e;
    logic        push_rdy;
    logic        pop_v;
    spc_entry_t  pop_e;
    logic        pop;
    logic [15:0] wr_fold;
    logic [15:0] rd_base;
    logic [15:0] rd_fold;
    logic        code_match;

    spc_fifo #(
        .WIDTH (`SPC_FIFO_WIDTH),
        .DEPTH (`SPC_FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (push_v),
        .in_ready  (push_rdy),
        .in_data   (push_e),
        .out_valid (pop_v),
        .out_ready (wr_ready),
        .out_data  (pop_e)
    );

    assign pop        = pop_v && wr_ready;
    assign wr_fold    = crc_step(c_r.rem, c_r.h1);
    assign rd_base    = rd_in.clear ? SEED_L : c_r.rd_rem; // [RULE3]
    assign rd_fold    = crc_step(rd_base, rd_in.data);
    assign code_match = ({c_r.h1, c_r.h0} == {c_r.rem[14:0], 1'b0});
    assign wr_out     = c_r.wr;
    assign rd_code    = c_r.rd_code;

    always_comb begin
        c_nxt          = c_r;
        push_v         = 1'b0;
        push_e         = '0;
        c_nxt.tog_s    = {c_r.tog_s[1:0], h_r.tog};
        c_nxt.cs_s     = {c_r.cs_s[1:0], link_cs_n};
        c_nxt.wr.valid = 1'b0;
        c_nxt.wr.done  = 1'b0;
        // intake: held byte first, then frame end
        if (c_r.cap_v) begin
            push_v      = 1'b1;
            push_e      = '{is_end: 1'b0, data: c_r.cap};
            c_nxt.cap_v = 1'b0;
            if (!push_rdy) begin
                c_nxt.ovf = 1'b1;
            end
        end else if (c_r.pend_end) begin
            push_v = 1'b1;
            push_e = '{is_end: 1'b1, data: {7'h00, c_r.ovf}};
            if (push_rdy) begin
                c_nxt.pend_end = 1'b0;
                c_nxt.ovf      = 1'b0;
            end
        end
        // byte arrival once stages two and three agree
        if (c_r.tog_s[1] == c_r.tog_s[2] &&
            c_r.tog_s[1] != c_r.tog_acc) begin
            c_nxt.tog_acc = c_r.tog_s[1];
            c_nxt.cap     = h_r.byte_hold;
            c_nxt.cap_v   = 1'b1;
        end
        // frame end on chip select release
        if (c_r.cs_s[1] == c_r.cs_s[2]) begin
            if (c_r.cs_s[1] && !c_r.cs_acc) begin
                c_nxt.pend_end = 1'b1; // [RULE1]
            end
            c_nxt.cs_acc = c_r.cs_s[1];
        end
        // check engine, last two bytes held back as the code
        if (pop) begin
            if (pop_e.is_end) begin
                c_nxt.wr.done = 1'b1;
                c_nxt.wr.ok   = (c_r.cnt == `SPC_CNT_FULL) &&
                                !pop_e.data[0] && code_match; // [RULE9]
                c_nxt.rem     = SEED_L; // [RULE3]
                c_nxt.cnt     = '0;
            end else begin
                if (c_r.cnt >= `SPC_CNT_CODE) begin
                    c_nxt.rem      = wr_fold; // [RULE5] [RULE7]
                    c_nxt.wr.data  = c_r.h1;
                    c_nxt.wr.valid = 1'b1;
                end
                c_nxt.h1 = c_r.h0;
                c_nxt.h0 = pop_e.data;
                if (c_r.cnt != `SPC_CNT_FULL) begin
                    c_nxt.cnt = c_r.cnt + 1'b1;
                end
            end
        end
        // code for outgoing read payload
        if (rd_in.clear || rd_in.valid) begin
            c_nxt.rd_rem = rd_in.valid ? rd_fold : rd_base; // [RULE1]
        end
        c_nxt.rd_code = {c_nxt.rd_rem[14:0], 1'b0}; // [RULE6]
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            c_r         <= '0;
            c_r.cs_s    <= '1;
            c_r.cs_acc  <= 1'b1;
            c_r.rem     <= SEED_L;
            c_r.rd_rem  <= SEED_L;
            c_r.rd_code <= SEED_CODE;
        end else begin
            c_r <= c_nxt;
        end
    end

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_fold_matches_bits: assert property ( // [RULE2] [RULE4]
        pop && !pop_e.is_end && c_r.cnt >= `SPC_CNT_CODE
        |-> wr_fold[14:0] == bit_step(c_r.rem, c_r.h1))
        else $error("table fold differs from bit serial fold");

    a_rd_code_step: assert property ( // [RULE5]
        rd_in.valid && !rd_in.clear
        |=> rd_code == {bit_step($past(c_r.rd_rem), $past(rd_in.data)),
                        1'b0})
        else $error("read code not folded from last byte");

    a_seed_reload: assert property ( // [RULE3]
        pop && pop_e.is_end
        |=> c_r.rem == SEED_L && c_r.cnt == 2'h0)
        else $error("remainder not preset after frame end");

    a_rd_seed: assert property ( // [RULE3]
        rd_in.clear && !rd_in.valid |=> rd_code == SEED_CODE)
        else $error("read code not at seed after clear");

    a_code_lsb_zero: assert property ( // [RULE6]
        $changed(c_r.rd_rem) |-> rd_code == {c_r.rd_rem[14:0], 1'b0})
        else $error("read code is not remainder times two");

    a_bad_code_refused: assert property ( // [RULE9]
        pop && pop_e.is_end && !code_match
        |=> wr_out.done && !wr_out.ok)
        else $error("mismatching frame reported good");

    a_byte_order: assert property ( // [RULE7]
        pop && !pop_e.is_end && c_r.cnt >= `SPC_CNT_CODE
        |=> wr_out.valid && wr_out.data == $past(c_r.h1))
        else $error("payload byte not delivered in order");

    a_end_queued: assert property ( // [RULE1]
        !c_r.cs_acc && c_r.cs_s[1] && c_r.cs_s[2] |=> c_r.pend_end)
        else $error("frame end not queued for checking");

    a_seed_then_fold: assert property ( // [RULE3] [RULE6]
        rd_in.clear && rd_in.valid
        |=> rd_code == {bit_step(SEED_L, $past(rd_in.data)), 1'b0})
        else $error("read code not seeded before fold");

    a_short_refused: assert property ( // [RULE9]
        pop && pop_e.is_end && c_r.cnt != `SPC_CNT_FULL
        |=> wr_out.done && !wr_out.ok)
        else $error("frame without full code reported good");

    a_ovf_refused: assert property ( // [RULE9]
        pop && pop_e.is_end && pop_e.data[0]
        |=> wr_out.done && !wr_out.ok)
        else $error("overflowed frame reported good");

    a_done_alone: assert property ( // [RULE7]
        wr_out.done |-> !wr_out.valid)
        else $error("frame end delivered with a payload byte");

    c_frame_ok:   cover property (wr_out.done && wr_out.ok);
    c_frame_bad:  cover property (wr_out.done && !wr_out.ok);
    c_fifo_full:  cover property (push_v && !push_rdy);
    c_seed_fold:  cover property (rd_in.clear && rd_in.valid);
    c_ovf_end:    cover property (pop && pop_e.is_end && pop_e.data[0]);

endmodule : spc_crc_link

// ### testbench/spc_link_master.sv
// link master model: sends frames on the serial command link
// assumes the bench calls its tasks; clock idles low between frames
`timescale 1ns/1ps
module spc_link_master (
    output logic link_clk,
    output logic link_cs_n,
    output logic link_mosi
);
    initial begin
        link_clk  = 1'b0;
        link_cs_n = 1'b1;
        link_mosi = 1'b0;
    end
    // free pulses, only while reset is held
    task automatic run_clk(input int n);
        repeat (n) begin
            #15 link_clk = 1'b1;
            #15 link_clk = 1'b0;
        end
    endtask : run_clk
    // bytes msb first in order, 30 ns clock on a short link
    task automatic send(input logic [7:0] b[$]);
        link_cs_n = 1'b0;
        #20;
        foreach (b[i]) begin
            for (int k = 7; k >= 0; k--) begin
                link_mosi = b[i][k];
                #15 link_clk = 1'b1;
                #15 link_clk = 1'b0;
            end
        end
        #20 link_cs_n = 1'b1;
        // released line does not keep its last level
        link_mosi = ~link_mosi;
    endtask : send
endmodule : spc_link_master

// ### testbench/tb_serial_packet_crc15.sv
// self-checking bench of the packet check unit
// assumes spc_link_master as the link partner
`timescale 1ns/1ps
module tb_serial_packet_crc15;
    import spc_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        wr_ready = 1'b1;
    logic        link_clk;
    logic        link_cs_n;
    logic        link_mosi;
    spc_wr_out_t wr_out;
    spc_rd_in_t  rd_in    = '0;
    logic [15:0] rd_code;
    int          error_cnt   = 0;
    int          check_count = 0;
    logic [7:0]  got[$];
    logic [7:0]  p[$];
    logic        done_seen = 1'b0;
    logic [55:0] rows [4] = '{56'h01_000000000000, 56'h02_010200000000,
                              56'h04_deadbeef0000, 56'h06_ff807f0055aa};

    always #25 core_clk = ~core_clk;

    spc_crc_link dut (
        .core_clk  (core_clk),
        .reset     (reset),
        .link_clk  (link_clk),
        .link_cs_n (link_cs_n),
        .link_mosi (link_mosi),
        .wr_ready  (wr_ready),
        .wr_out    (wr_out),
        .rd_in     (rd_in),
        .rd_code   (rd_code)
    );

    spc_link_master mst (
        .link_clk  (link_clk),
        .link_cs_n (link_cs_n),
        .link_mosi (link_mosi)
    );

    always @(negedge core_clk) begin
        if (wr_out.valid === 1'b1) got.push_back(wr_out.data);
        if (wr_out.done === 1'b1) done_seen = 1'b1;
    end

    function automatic logic [15:0] ref_code(input logic [7:0] b[$]);
        logic [15:0] rem;
        logic [15:0] t;
        rem = 16'h0010;
        foreach (b[i]) begin
            t = {1'b0, rem[14:7] ^ b[i], 7'h00};
            for (int k = 0; k < 8; k++)
                t = t[14] ? ((t << 1) ^ 16'h4599) : (t << 1);
            rem = (rem << 8) ^ t;
        end
        return {rem[14:0], 1'b0};
    endfunction : ref_code

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic rd(input logic [7:0] b[$]);
        @(negedge core_clk);
        rd_in = '{clear: 1'b1, valid: 1'b0, data: 8'h00};
        foreach (b[i]) begin
            @(negedge core_clk);
            rd_in = '{clear: 1'b0, valid: 1'b1, data: b[i]};
        end
        @(negedge core_clk);
        rd_in = '0;
        @(negedge core_clk);
        check("rd_code", rd_code, ref_code(b));
        $display("read code test done");
    endtask : rd

    task automatic frame(input logic [7:0] b[$], input logic [15:0] code,
                         input logic exp_ok);
        logic [7:0] f[$];
        int         n;
        f = b;
        f.push_back(code[15:8]);
        f.push_back(code[7:0]);
        got.delete();
        done_seen = 1'b0;
        mst.send(f);
        n = 0;
        while (done_seen !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (done_seen !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end else begin
            repeat (2) @(negedge core_clk);
            check("ok", {15'h0, wr_out.ok}, {15'h0, exp_ok});
            if (exp_ok) begin
                check("count", 16'(got.size()), 16'(b.size()));
                foreach (b[i]) begin
                    check("byte", {8'h0, got[i]}, {8'h0, b[i]});
                end
            end
            repeat (8) @(negedge core_clk);
            $display("frame of %0d bytes done", f.size());
        end
    endtask : frame

    initial begin
        fork
            mst.run_clk(6);
            repeat (3) @(negedge core_clk);
        join
        @(negedge core_clk);
        reset = 1'b0;
        check("rd_seed", rd_code, 16'h0020);
        check("wr_idle", {5'h0, wr_out}, 16'h0000);
        $display("reset test done");
        p.delete();
        rd(p);
        for (int r = 0; r < 4; r++) begin
            p.delete();
            for (int i = 0; i < rows[r][55:48]; i++)
                p.push_back(rows[r][47-8*i -: 8]);
            rd(p);
            frame(p, ref_code(p), 1'b1);
        end
        frame(p, ref_code(p) ^ 16'h0002, 1'b0);
        frame(p, ref_code(p) ^ 16'h0001, 1'b0);
        @(negedge core_clk);
        rd_in = '{clear: 1'b1, valid: 1'b1, data: 8'h00};
        @(negedge core_clk);
        rd_in = '0;
        @(negedge core_clk);
        check("rd_seed_fold", rd_code, 16'h2000);
        $display("seed and fold test done");
        p.delete();
        frame(p, ref_code(p), 1'b0);
        p.delete();
        for (int i = 0; i < 12; i++) p.push_back(8'(8'h30 + i));
        wr_ready = 1'b0;
        fork
            frame(p, ref_code(p), 1'b0);
            begin
                repeat (100) @(negedge core_clk);
                wr_ready = 1'b1;
            end
        join
        $display("overflow test done");
        frame(p[0:3], ref_code(p[0:3]), 1'b1);
        wrap_up();
    end
endmodule : tb_serial_packet_crc15
